// File: rtl/pin_input_pkg.sv
// Package with register map, field layout, reset values and timing constants of the pin input block
`default_nettype none
package pin_input_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [13:0] IDX_E_IN_EN   = 14'h30BC;
  localparam logic [13:0] IDX_F_IN_EN   = 14'h30BD;
  localparam logic [13:0] IDX_G_IN_EN   = 14'h30BE;
  localparam logic [13:0] IDX_H_IN_EN   = 14'h30BF;
  localparam logic [13:0] IDX_FILT_SEL0 = 14'h30EC;
  localparam logic [13:0] IDX_FILT_DIV  = 14'h30EF;

  localparam logic [15:0] ADDR_E_IN_EN   = {IDX_E_IN_EN, 2'h0};
  localparam logic [15:0] ADDR_F_IN_EN   = {IDX_F_IN_EN, 2'h0};
  localparam logic [15:0] ADDR_G_IN_EN   = {IDX_G_IN_EN, 2'h0};
  localparam logic [15:0] ADDR_H_IN_EN   = {IDX_H_IN_EN, 2'h0};
  localparam logic [15:0] ADDR_FILT_SEL0 = {IDX_FILT_SEL0, 2'h0};
  localparam logic [15:0] ADDR_FILT_DIV  = {IDX_FILT_DIV, 2'h0};

  // Writable bit masks; zero bits are reserved and read as zero
  localparam logic [7:0] MASK_E_IN_EN   = 8'hFF;
  localparam logic [7:0] MASK_F_IN_EN   = 8'hFF;
  localparam logic [7:0] MASK_G_IN_EN   = 8'h0F;
  localparam logic [7:0] MASK_H_IN_EN   = 8'hC7;
  localparam logic [7:0] MASK_FILT_SEL0 = 8'hFF;
  localparam logic [7:0] MASK_FILT_DIV  = 8'hFF;

  // Values after reset
  localparam logic [7:0] RST_IN_EN     = 8'h00;
  localparam logic [7:0] RST_FILT_SEL0 = 8'h00;
  localparam logic [7:0] RST_FILT_DIV  = 8'h00;

  // Filter select field positions, two bits each
  localparam int FSEL_W     = 2;
  localparam int FSEL_A_LSB = 0;
  localparam int FSEL_B_LSB = 2;
  localparam int FSEL_C_LSB = 4;
  localparam int FSEL_D_LSB = 6;

  // Filter source codes
  localparam logic [1:0] SRC_BUS  = 2'h0;
  localparam logic [1:0] SRC_DIV1 = 2'h1;
  localparam logic [1:0] SRC_DIV2 = 2'h2;
  localparam logic [1:0] SRC_DIV3 = 2'h3;

  // Divider register fields
  localparam int DIV1_LSB = 0;
  localparam int DIV1_W   = 2;
  localparam int DIV2_LSB = 2;
  localparam int DIV2_W   = 3;
  localparam int DIV3_LSB = 5;
  localparam int DIV3_W   = 3;
  localparam int DIV1_BASE_SHIFT = 1;   // Code 0 divides by 2
  localparam int DIV2_BASE_SHIFT = 5;   // Code 0 divides by 32

  // Timing: bus clock and the low power reference rate
  localparam int BUS_CLK_HZ   = 50_000_000;
  localparam int LPO_CLK_HZ   = 1_000;
  localparam int LPO_CYCLES   = BUS_CLK_HZ / LPO_CLK_HZ;
  localparam int PRESCALE_W   = 12;
  localparam int LPO_PRE_W    = 7;

endpackage
`default_nettype wire

// File: rtl/glitch_filter.sv
// One pin glitch filter: output follows input only after two agreeing samples
`timescale 1ns/1ps
`default_nettype none
module glitch_filter
  import pin_input_pkg::*;
(
  input  wire logic clk_i,     // Bus clock
  input  wire logic rst_i,     // Synchronous reset, active high
  input  wire logic sample_i,  // Sample enable from the selected filter rate
  input  wire logic pin_i,     // Synchronised pin level
  output logic      level_o    // Filtered level
);

  logic last_r;
  logic level_r;

  // Two samples one filter period apart must agree before the output moves
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      last_r  <= 1'b0;
      level_r <= 1'b0;
    end
    else if (sample_i)
    begin
      last_r <= pin_i;
      if (pin_i == last_r)
        level_r <= pin_i;
    end
  end

  assign level_o = level_r;

  // Output only moves on a sample pulse and only toward two agreeing samples
  a_filter_moves_on_sample: assert property (@(posedge clk_i) disable iff (rst_i)
    (level_r != $past(level_r)) |-> ($past(sample_i) && $past(pin_i) == $past(last_r)))
    else $error("filter output moved without two agreeing samples");

endmodule
`default_nettype wire

// File: rtl/pin_input_ctrl.sv
// Pin input enable registers and port A to D glitch filter selection with Avalon-MM access
//
// How it works
// - All eight bits of the port E input enable register gate each pin's input, 1 on and 0 off, read/write.
// - Port F input enable holds eight read/write bits, one per pin, 1 enables the input.
// - Port G input enable has read/write bits only at positions 3 to 0, 1 enables the input.
// - Port G input enable bits 7 to 4 are reserved and always read zero.
// - Port H input enable has read/write bits at 7, 6, 2, 1 and 0, 1 enables the input.
// - Port H input enable bits 5 to 3 are reserved and always read zero.
// - Filter select register zero configures filters of ports A to D with a two-bit field each.
// - Bits 7 to 6 pick port D's filter clock: bus, divided clock 1, 2 or 3.
// - Bits 5 to 4 pick port C's filter clock with the same encoding.
// - Bits 3 to 2 pick port B's and bits 1 to 0 port A's filter clock, same encoding.
// - Glitches shorter than one filter period are dropped; pulses over two periods pass.
// - Divided filter clock 1 is the bus clock over 2, 4, 8 or 16 by a two-bit code.
`timescale 1ns/1ps
`default_nettype none
module pin_input_ctrl
  import pin_input_pkg::*;
#(
  parameter int LPO_DIV_CYCLES = LPO_CYCLES  // Bus cycles per low power reference tick
)
(
  input  wire logic        clk_i,              // Bus clock, 50 MHz
  input  wire logic        rst_i,              // Synchronous reset, active high
  input  wire logic [15:0] avs_address_i,      // Byte address
  input  wire logic        avs_read_i,         // Read request
  input  wire logic        avs_write_i,        // Write request
  input  wire logic [31:0] avs_writedata_i,    // Write data, low byte used
  input  wire logic [3:0]  avs_byteenable_i,   // Byte enables, lane 0 used
  output logic      [31:0] avs_readdata_o,     // Read data
  output logic             avs_waitrequest_o,  // Stall, low for the answer cycle
  input  wire logic [7:0]  port_a_pin_i,       // Port A pins
  input  wire logic [7:0]  port_b_pin_i,       // Port B pins
  input  wire logic [7:0]  port_c_pin_i,       // Port C pins
  input  wire logic [7:0]  port_d_pin_i,       // Port D pins
  input  wire logic [7:0]  port_e_pin_i,       // Port E pins
  input  wire logic [7:0]  port_f_pin_i,       // Port F pins
  input  wire logic [7:0]  port_g_pin_i,       // Port G pins
  input  wire logic [7:0]  port_h_pin_i,       // Port H pins
  output logic      [7:0]  port_a_in_o,        // Filtered port A inputs
  output logic      [7:0]  port_b_in_o,        // Filtered port B inputs
  output logic      [7:0]  port_c_in_o,        // Filtered port C inputs
  output logic      [7:0]  port_d_in_o,        // Filtered port D inputs
  output logic      [7:0]  port_e_in_o,        // Gated port E inputs
  output logic      [7:0]  port_f_in_o,        // Gated port F inputs
  output logic      [7:0]  port_g_in_o,        // Gated port G inputs
  output logic      [7:0]  port_h_in_o,        // Gated port H inputs
  output logic      [7:0]  east_pin_in_en_o,   // Port E input buffer enables
  output logic      [7:0]  fifth_group_in_en_o,   // Port F input buffer enables
  output logic      [7:0]  seventh_group_in_en_o, // Port G input buffer enables
  output logic      [7:0]  eighth_group_in_en_o   // Port H input buffer enables
);

  // Configuration registers
  logic [7:0]  east_pin_in_en_r;
  logic [7:0]  fifth_group_in_en_r;
  logic [7:0]  seventh_group_in_en_r;
  logic [7:0]  eighth_group_in_en_r;
  logic [7:0]  filter_select_reg_zero_r;
  logic [7:0]  filter_div_r;

  // Bus handshake
  logic        wait_r;
  logic [31:0] readdata_r;
  logic [7:0]  rd_nxt;
  logic        req;
  logic        wr_ok;

  // Pin synchronisers
  logic [63:0] pin_meta_r;
  logic [63:0] pin_sync_r;
  logic [63:0] pin_all;

  // Filter rate generation
  logic [PRESCALE_W-1:0] pre_cnt_r;
  logic [PRESCALE_W-1:0] div1_mask;
  logic [PRESCALE_W-1:0] div2_mask;
  logic [31:0]           lpo_cnt_r;
  logic                  lpo_tick_r;
  logic [LPO_PRE_W-1:0]  lpo_pre_r;
  logic [LPO_PRE_W-1:0]  div3_mask;
  logic                  filter_clock_div_one_r;
  logic                  filter_clock_div_two_r;
  logic                  filter_clock_div_three_r;

  // Filter path
  logic [3:0]  grp_sample;
  logic [31:0] filt_level;
  logic [31:0] filt_out_r;
  logic [31:0] gated_out_r;

  assign req   = avs_read_i | avs_write_i;
  assign wr_ok = avs_write_i & ~wait_r & avs_byteenable_i[0];

  // Waitrequest is high when idle and drops for exactly one cycle per request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wait_r <= 1'b1;
    else
      wait_r <= ~(req & wait_r);
  end

  // Read mux; unmapped addresses read as zero
  always_comb
  begin
    unique case (avs_address_i)
      ADDR_E_IN_EN:   rd_nxt = east_pin_in_en_r;
      ADDR_F_IN_EN:   rd_nxt = fifth_group_in_en_r;
      ADDR_G_IN_EN:   rd_nxt = seventh_group_in_en_r & MASK_G_IN_EN;
      ADDR_H_IN_EN:   rd_nxt = eighth_group_in_en_r & MASK_H_IN_EN;
      ADDR_FILT_SEL0: rd_nxt = filter_select_reg_zero_r;
      ADDR_FILT_DIV:  rd_nxt = filter_div_r;
      default:        rd_nxt = 8'h00;
    endcase
  end

  // Read data captured in the stall cycle so it stands when waitrequest drops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      readdata_r <= 32'h0000_0000;
    else if (avs_read_i & wait_r)
      readdata_r <= {24'h00_0000, rd_nxt};
  end

  // Register writes take effect at the edge where waitrequest is seen low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      east_pin_in_en_r         <= RST_IN_EN;
      fifth_group_in_en_r      <= RST_IN_EN;
      seventh_group_in_en_r    <= RST_IN_EN;
      eighth_group_in_en_r     <= RST_IN_EN;
      filter_select_reg_zero_r <= RST_FILT_SEL0;
      filter_div_r             <= RST_FILT_DIV;
    end
    else if (wr_ok)
    begin
      unique case (avs_address_i)
        ADDR_E_IN_EN:   east_pin_in_en_r      <= avs_writedata_i[7:0] & MASK_E_IN_EN;
        ADDR_F_IN_EN:   fifth_group_in_en_r   <= avs_writedata_i[7:0] & MASK_F_IN_EN;
        ADDR_G_IN_EN:   seventh_group_in_en_r <= avs_writedata_i[7:0] & MASK_G_IN_EN;
        ADDR_H_IN_EN:   eighth_group_in_en_r  <= avs_writedata_i[7:0] & MASK_H_IN_EN;
        ADDR_FILT_SEL0: filter_select_reg_zero_r <= avs_writedata_i[7:0] & MASK_FILT_SEL0;
        ADDR_FILT_DIV:  filter_div_r          <= avs_writedata_i[7:0] & MASK_FILT_DIV;
        default:        ;
      endcase
    end
  end

  assign avs_waitrequest_o     = wait_r;
  assign avs_readdata_o        = readdata_r;
  assign east_pin_in_en_o      = east_pin_in_en_r;
  assign fifth_group_in_en_o   = fifth_group_in_en_r;
  assign seventh_group_in_en_o = seventh_group_in_en_r;
  assign eighth_group_in_en_o  = eighth_group_in_en_r;

  // Pins are asynchronous to the bus clock: two flops before any logic
  assign pin_all = {port_h_pin_i, port_g_pin_i, port_f_pin_i, port_e_pin_i,
                    port_d_pin_i, port_c_pin_i, port_b_pin_i, port_a_pin_i};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta_r <= 64'h0;
      pin_sync_r <= 64'h0;
    end
    else
    begin
      pin_meta_r <= pin_all;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Binary prescaler; the masks pick power-of-two taps for divided clocks 1 and 2
  assign div1_mask = ~({PRESCALE_W{1'b1}} << (DIV1_BASE_SHIFT
                     + int'(filter_div_r[DIV1_LSB +: DIV1_W])));
  assign div2_mask = ~({PRESCALE_W{1'b1}} << (DIV2_BASE_SHIFT
                     + int'(filter_div_r[DIV2_LSB +: DIV2_W])));
  assign div3_mask = ~({LPO_PRE_W{1'b1}} << int'(filter_div_r[DIV3_LSB +: DIV3_W]));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pre_cnt_r <= '0;
    else
      pre_cnt_r <= pre_cnt_r + 1'b1;
  end

  // One-cycle enables at the divided rates; no derived clocks are made
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      filter_clock_div_one_r <= 1'b0;
      filter_clock_div_two_r <= 1'b0;
    end
    else
    begin
      filter_clock_div_one_r <= (pre_cnt_r & div1_mask) == div1_mask;
      filter_clock_div_two_r <= (pre_cnt_r & div2_mask) == div2_mask;
    end
  end

  // Low power reference is stood in for by a long bus clock divider
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lpo_cnt_r  <= 32'h0;
      lpo_tick_r <= 1'b0;
    end
    else if (lpo_cnt_r >= 32'(LPO_DIV_CYCLES - 1))
    begin
      lpo_cnt_r  <= 32'h0;
      lpo_tick_r <= 1'b1;
    end
    else
    begin
      lpo_cnt_r  <= lpo_cnt_r + 32'h1;
      lpo_tick_r <= 1'b0;
    end
  end

  // Divided clock 3 is the reference rate over 1 to 128
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lpo_pre_r                <= '0;
      filter_clock_div_three_r <= 1'b0;
    end
    else
    begin
      if (lpo_tick_r)
        lpo_pre_r <= lpo_pre_r + 1'b1;
      filter_clock_div_three_r <= lpo_tick_r & ((lpo_pre_r & div3_mask) == div3_mask);
    end
  end

  // Per port sample enable from its select field
  generate
    for (genvar p = 0; p < 4; p++)
    begin : g_sel
      logic [1:0] sel;
      assign sel = filter_select_reg_zero_r[2*p +: FSEL_W];
      assign grp_sample[p] = (sel == SRC_BUS)  ? 1'b1 :
                             (sel == SRC_DIV1) ? filter_clock_div_one_r :
                             (sel == SRC_DIV2) ? filter_clock_div_two_r :
                                                 filter_clock_div_three_r;
    end
  endgenerate

  // One filter per pin of ports A to D
  generate
    for (genvar i = 0; i < 32; i++)
    begin : g_filt
      glitch_filter u_filt (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .sample_i (grp_sample[i/8]),
        .pin_i    (pin_sync_r[i]),
        .level_o  (filt_level[i])
      );
    end
  endgenerate

  // Filtered levels registered so outputs leave from flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      filt_out_r <= 32'h0;
    else
      filt_out_r <= filt_level;
  end

  // Disabled inputs read as zero whatever the pin does
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      gated_out_r <= 32'h0;
    else
      gated_out_r <= pin_sync_r[63:32] & {eighth_group_in_en_r, seventh_group_in_en_r,
                                          fifth_group_in_en_r, east_pin_in_en_r};
  end

  assign port_a_in_o = filt_out_r[7:0];
  assign port_b_in_o = filt_out_r[15:8];
  assign port_c_in_o = filt_out_r[23:16];
  assign port_d_in_o = filt_out_r[31:24];
  assign port_e_in_o = gated_out_r[7:0];
  assign port_f_in_o = gated_out_r[15:8];
  assign port_g_in_o = gated_out_r[23:16];
  assign port_h_in_o = gated_out_r[31:24];

  // Every request is answered one cycle later and the stall returns after it
  a_wait_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && avs_waitrequest_o) |=> (!avs_waitrequest_o ##1 avs_waitrequest_o))
    else $error("waitrequest did not drop for exactly one cycle");

  // Port G reserved bits never read back as one
  a_g_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (!avs_waitrequest_o && $past(avs_address_i) == ADDR_G_IN_EN && $past(avs_read_i))
      |-> avs_readdata_o[7:4] == 4'h0)
    else $error("port G reserved bits read as one");

  // Port H reserved bits never read back as one
  a_h_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (!avs_waitrequest_o && $past(avs_address_i) == ADDR_H_IN_EN && $past(avs_read_i))
      |-> avs_readdata_o[5:3] == 3'h0)
    else $error("port H reserved bits read as one");

  // Reserved register bits stay zero across any write
  a_reserved_held: assert property (@(posedge clk_i) disable iff (rst_i)
    (seventh_group_in_en_o[7:4] == 4'h0) && (eighth_group_in_en_o[5:3] == 3'h0))
    else $error("reserved enable bit became one");

  // A port F write lands in the register at the accepted edge and is seen at the next edge
  a_f_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
      && avs_address_i == ADDR_F_IN_EN) |=> fifth_group_in_en_o == $past(avs_writedata_i[7:0]))
    else $error("port F enable write lost");

  // Port E input is zero where its enable was clear
  a_e_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (port_e_in_o & ~$past(east_pin_in_en_o)) == 8'h00)
    else $error("disabled port E input not zero");

  // Disabled port G and H pins present zero
  a_gh_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ((port_g_in_o & ~$past(seventh_group_in_en_o)) == 8'h00)
      && ((port_h_in_o & ~$past(eighth_group_in_en_o)) == 8'h00))
    else $error("disabled port G or H input not zero");

  // Divided clock 1 at code 0 pulses every second bus cycle
  // The code must still be zero one cycle on, since a write may retune the divider there
  a_div1_rate: assert property (@(posedge clk_i) disable iff (rst_i)
    (filter_clock_div_one_r && filter_div_r[DIV1_LSB +: DIV1_W] == 2'h0
      && $stable(filter_div_r)) ##1 (filter_div_r[DIV1_LSB +: DIV1_W] == 2'h0)
      |-> !filter_clock_div_one_r ##1 filter_clock_div_one_r)
    else $error("divided clock 1 rate wrong");

  // Bus clock selection on port A samples every cycle
  a_a_bus_sample: assert property (@(posedge clk_i) disable iff (rst_i)
    (filter_select_reg_zero_r[FSEL_A_LSB +: FSEL_W] == SRC_BUS) |-> grp_sample[0])
    else $error("port A bus clock filter not sampling");

  // Port D on divided clock 2 samples only on that enable
  a_d_div2_sample: assert property (@(posedge clk_i) disable iff (rst_i)
    (filter_select_reg_zero_r[FSEL_D_LSB +: FSEL_W] == SRC_DIV2)
      |-> grp_sample[3] == filter_clock_div_two_r)
    else $error("port D filter sample source wrong");

  // Port C on divided clock 3 samples only on that enable
  a_c_div3_sample: assert property (@(posedge clk_i) disable iff (rst_i)
    (filter_select_reg_zero_r[FSEL_C_LSB +: FSEL_W] == SRC_DIV3)
      |-> grp_sample[2] == filter_clock_div_three_r)
    else $error("port C filter sample source wrong");

endmodule
`default_nettype wire

// File: verification/pin_input_ctrl_bench.sv
// Self-checking bench for the pin input enable and filter select block
`timescale 1ns/1ps
`default_nettype none
module pin_input_ctrl_bench;
  import pin_input_pkg::*;

  localparam int LPO_SIM = 8;  // Short reference tick keeps divided clock 3 quick in sim
  localparam logic [15:0] EN_ADDR [4] = '{ADDR_E_IN_EN, ADDR_F_IN_EN, ADDR_G_IN_EN, ADDR_H_IN_EN};
  localparam logic [7:0]  EN_MASK [4] = '{8'hFF, 8'hFF, 8'h0F, 8'hC7};
  // Pulse lengths against periods 1, 2, 32 and 8 on ports A to D, and the ports that pass
  localparam int          MIX_LEN [3] = '{5, 20, 70};
  localparam logic [3:0]  MIX_HI  [3] = '{4'h3, 4'hB, 4'hF};

  logic        clk_i            = 1'b0;
  logic        rst_i            = 1'b1;
  logic [15:0] avs_address_i    = 16'h0000;
  logic        avs_read_i       = 1'b0;
  logic        avs_write_i      = 1'b0;
  logic [31:0] avs_writedata_i  = 32'h00000000;
  logic [3:0]  avs_byteenable_i = 4'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [7:0]  pin_in   [8] = '{default: 8'hFF};  // Pins A to H, high through reset
  logic [7:0]  port_out [8];                      // Filtered or gated inputs A to H
  logic [7:0]  en_out   [4];                      // Enable outputs E to H
  logic [3:0]  hi;
  logic [31:0] rdata;
  int          n_mismatch  = 0;
  int          comparisons = 0;

  // 50 MHz bus clock
  always #10 clk_i = ~clk_i;

  pin_input_ctrl #(
    .LPO_DIV_CYCLES (LPO_SIM)
  ) DUT (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .avs_address_i         (avs_address_i),
    .avs_read_i            (avs_read_i),
    .avs_write_i           (avs_write_i),
    .avs_writedata_i       (avs_writedata_i),
    .avs_byteenable_i      (avs_byteenable_i),
    .avs_readdata_o        (avs_readdata_o),
    .avs_waitrequest_o     (avs_waitrequest_o),
    .port_a_pin_i          (pin_in[0]),
    .port_b_pin_i          (pin_in[1]),
    .port_c_pin_i          (pin_in[2]),
    .port_d_pin_i          (pin_in[3]),
    .port_e_pin_i          (pin_in[4]),
    .port_f_pin_i          (pin_in[5]),
    .port_g_pin_i          (pin_in[6]),
    .port_h_pin_i          (pin_in[7]),
    .port_a_in_o           (port_out[0]),
    .port_b_in_o           (port_out[1]),
    .port_c_in_o           (port_out[2]),
    .port_d_in_o           (port_out[3]),
    .port_e_in_o           (port_out[4]),
    .port_f_in_o           (port_out[5]),
    .port_g_in_o           (port_out[6]),
    .port_h_in_o           (port_out[7]),
    .east_pin_in_en_o      (en_out[0]),
    .fifth_group_in_en_o   (en_out[1]),
    .seventh_group_in_en_o (en_out[2]),
    .eighth_group_in_en_o  (en_out[3])
  );

  // Verdict and end of run; also reached when a wait runs out
  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon access; entered just after an edge, returns one edge after release
  task automatic bus_op(input logic wr, input logic [15:0] addr, input logic [7:0] data,
                        input logic be0, output logic [31:0] rd);
    int n;
    avs_address_i    <= addr;
    avs_writedata_i  <= {24'h000000, data};
    avs_byteenable_i <= {3'h0, be0};
    avs_write_i      <= wr;
    avs_read_i       <= ~wr;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 20);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (n >= 20)
    begin
      n_mismatch++;
      $display("MISMATCH waitrequest expected 0 seen %b", avs_waitrequest_o);
      close_out();
    end
    @(posedge clk_i);
  endtask

  task automatic wr_reg(input logic [15:0] addr, input logic [7:0] data);
    logic [31:0] dummy;
    bus_op(1'b1, addr, data, 1'b1, dummy);
  endtask

  task automatic rd_chk(input string what, input logic [15:0] addr, input logic [7:0] exp);
    logic [31:0] rd;
    bus_op(1'b0, addr, 8'h00, 1'b1, rd);
    chk(what, 32'(exp), rd);
  endtask

  // Drives ports A to D high for len cycles, notes which filtered port ever rose
  task automatic pulse(input int len, input int win);
    hi = 4'h0;
    for (int k = 0; k < 4; k++)
      pin_in[k] <= 8'hFF;
    for (int i = 1; i <= win; i++)
    begin
      @(posedge clk_i);
      if (i == len)
        for (int k = 0; k < 4; k++)
          pin_in[k] <= 8'h00;
      for (int k = 0; k < 4; k++)
        hi[k] = hi[k] | (|port_out[k]);
    end
  endtask

  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 4; k++)
      pin_in[k] <= 8'h00;
    @(posedge clk_i);
    // Out of reset: every enable clear, so the high pins show as zero
    foreach (EN_ADDR[i])
    begin
      chk("enable out at reset", 32'h0, 32'(en_out[i]));
      chk("gated in at reset", 32'h0, 32'(port_out[i + 4]));
      rd_chk("enable reg at reset", EN_ADDR[i], 8'h00);
    end
    rd_chk("filter select at reset", ADDR_FILT_SEL0, 8'h00);
    // Two patterns per enable register; reserved bits stay zero
    foreach (EN_ADDR[i])
    begin
      wr_reg(EN_ADDR[i], 8'h5A);
      rd_chk("enable reg 5A", EN_ADDR[i], 8'h5A & EN_MASK[i]);
      wr_reg(EN_ADDR[i], 8'hFF);
      rd_chk("enable reg FF", EN_ADDR[i], EN_MASK[i]);
      chk("enable out", 32'(EN_MASK[i]), 32'(en_out[i]));
    end
    // Write with lane 0 disabled must not touch the register
    bus_op(1'b1, ADDR_E_IN_EN, 8'h00, 1'b0, rdata);
    rd_chk("masked write", ADDR_E_IN_EN, 8'hFF);
    // Unmapped place reads zero after a write
    wr_reg(ADDR_FILT_SEL0 + 16'h0004, 8'hFF);
    rd_chk("unmapped", ADDR_FILT_SEL0 + 16'h0004, 8'h00);
    // Gating: enabled pins pass after the sync delay, disabled pins read zero
    for (int k = 4; k < 8; k++)
      pin_in[k] <= 8'hA5;
    repeat (5) @(posedge clk_i);
    foreach (EN_ADDR[i])
      chk("gated in enabled", 32'(8'hA5 & EN_MASK[i]), 32'(port_out[i + 4]));
    wr_reg(ADDR_F_IN_EN, 8'h0F);
    wr_reg(ADDR_H_IN_EN, 8'h00);
    repeat (5) @(posedge clk_i);
    chk("port F half gated", 32'h05, 32'(port_out[5]));
    chk("port H gated off", 32'h00, 32'(port_out[7]));
    chk("port E still on", 32'hA5, 32'(port_out[4]));
    // Every source code in every field, then a mixed pattern
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(ADDR_FILT_SEL0, {4{2'(c)}});
      rd_chk("filter select code", ADDR_FILT_SEL0, {4{2'(c)}});
    end
    wr_reg(ADDR_FILT_SEL0, 8'hE4);
    rd_chk("filter select mixed", ADDR_FILT_SEL0, 8'hE4);
    // Divided clock 1 at /4, /8, /16 on two ports, bus clock on the other two
    for (int code = 1; code < 4; code++)
    begin
      wr_reg(ADDR_FILT_DIV, 8'(code));
      for (int s = 0; s < 2; s++)
      begin
        wr_reg(ADDR_FILT_SEL0, (s == 0) ? 8'h11 : 8'h44);
        pulse((2 << code) - 1, 3 * (2 << code) + 8);
        chk("short pulse", (s == 0) ? 32'hA : 32'h5, 32'(hi));
        pulse(2 * (2 << code) + 2, 5 * (2 << code) + 10);
        chk("long pulse", 32'hF, 32'(hi));
        for (int k = 0; k < 4; k++)
          chk("filtered idle", 32'h0, 32'(port_out[k]));
      end
    end
    // Divided clocks 2 and 3 beside divided clock 1 at /2 and the bus clock
    wr_reg(ADDR_FILT_DIV, 8'h00);
    wr_reg(ADDR_FILT_SEL0, 8'hE4);
    foreach (MIX_LEN[j])
    begin
      pulse(MIX_LEN[j], MIX_LEN[j] + 90);
      chk("mixed source pulse", 32'(MIX_HI[j]), 32'(hi));
      for (int k = 0; k < 4; k++)
        chk("mixed idle", 32'h0, 32'(port_out[k]));
    end
    // Reset in mid-run: stall high at once, enables and filter select back to zero
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("waitrequest after reset", 32'h1, 32'(avs_waitrequest_o));
    foreach (EN_ADDR[i])
    begin
      chk("gated in after reset", 32'h0, 32'(port_out[i + 4]));
      rd_chk("enable reg after reset", EN_ADDR[i], 8'h00);
    end
    rd_chk("filter select after reset", ADDR_FILT_SEL0, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
